// >>> fbsmc_pkg.sv
// fbsmc_pkg: constants, register map and state types of the mode configuration block
// assumes a 25 MHz sys_clk and a 32-bit Avalon-MM slave port with byte addresses
// Notes on behaviour
// - ready advance clear: ready only when read data valid or write data taken
// - ready advance set: ready comes one clock cycle earlier than default
// - synchronised-output mode supported only while sync capability field is one
// - input-latching freeze mode supported only while freeze capability field is one
// - protocol enable field one enables protocol and sets up all service points
// - after end of interrupt, output held inactive at least 1 us or 1 ms
// - user tick interrupt every 1 ms, or every 10 ms with timebase set
// - watchdog test field zero keeps the watchdog in normal functional mode
// - direct parameter buffer field one stores parameter data in special buffer
// - fail-safe clear field one accepts data telegrams with zero data length
package fbsmc_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // register byte offsets
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_MASK = 5'h0C;

  // control command bits (write), status bits of the control word (read)
  localparam int CTRL_START = 0;
  localparam int CTRL_EOI = 1;
  localparam int CTRL_OFFLINE = 2;

  // interrupt status and mask layout
  localparam int IRQ_W = 2;
  localparam int IRQ_TICK = 0;
  localparam int IRQ_REFUSED = 1;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

  // configuration word: writable bits and reset value
  localparam logic [15:0] CFG_WR_MASK = 16'h3FFF;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // wait cycles before ready, counted from the first sampled request edge
  localparam logic [1:0] LAT_NORMAL = 2'h2;
  localparam logic [1:0] LAT_EARLY = 2'h1;

  // times as printed, then cycle counts
  localparam int REL_SHORT_NS = 1000;
  localparam int REL_LONG_US = 1000;
  localparam int TICK_SHORT_US = 1000;
  localparam int TICK_LONG_US = 10000;
  localparam int REL_SHORT_CYC = (REL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_LONG_CYC = (REL_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_SHORT_CYC = (TICK_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int TICK_LONG_CYC = (TICK_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int REL_W = 15;
  localparam int TICK_W = 18;

  typedef struct packed {
    logic [1:0] reserved;
    logic failSafeClear;
    logic directParamBuf;
    logic watchdogTestSelect;
    logic userTimebase;
    logic irqReleaseTimebase;
    logic slaveProtocolEnable;
    logic freezeSupported;
    logic syncSupported;
    logic readyAdvance;
    logic [4:0] lowerFields;
  } fbsmc_cfg_t;

  typedef struct packed {
    fbsmc_cfg_t cfg;
    logic online;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic waitReq;
    logic [1:0] cnt;
    logic [31:0] rdata;
    logic [TICK_W-1:0] tickCnt;
    logic tickPulse;
    logic [REL_W-1:0] relCnt;
    logic irq;
  } fbsmc_state_t;

  localparam fbsmc_state_t STATE_RST = '{waitReq: 1'b1, default: '0};

endpackage

// >>> fbsmc_mode_config.sv
// fbsmc_mode_config: mode configuration register, bus ready timing, tick and interrupt
// assumes an Avalon-MM master on sys_clk that holds each request until waitrequest is low
`timescale 1ns/10ps
module fbsmc_mode_config #(
  parameter int REL_LONG_CYC = fbsmc_pkg::REL_LONG_CYC,
  parameter int TICK_SHORT_CYC = fbsmc_pkg::TICK_SHORT_CYC,
  parameter int TICK_LONG_CYC = fbsmc_pkg::TICK_LONG_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // mode fields and device state
  output fbsmc_pkg::fbsmc_cfg_t modeCfg,
  output logic protocolServicePoints,
  output logic online,
  output logic userTick,
  output logic irq
);

  if (REL_LONG_CYC < fbsmc_pkg::REL_SHORT_CYC || REL_LONG_CYC >= 2 ** fbsmc_pkg::REL_W)
  begin : g_bad_rel
    $error("release count does not fit its counter");
  end
  if (TICK_SHORT_CYC < 2 || TICK_SHORT_CYC > 2 ** fbsmc_pkg::TICK_W
      || TICK_LONG_CYC < 2 || TICK_LONG_CYC > 2 ** fbsmc_pkg::TICK_W)
  begin : g_bad_tick
    $error("tick period does not fit its counter");
  end

  localparam logic [fbsmc_pkg::REL_W-1:0] REL_S = fbsmc_pkg::REL_W'(fbsmc_pkg::REL_SHORT_CYC);
  localparam logic [fbsmc_pkg::REL_W-1:0] REL_L = fbsmc_pkg::REL_W'(REL_LONG_CYC);
  localparam logic [fbsmc_pkg::TICK_W-1:0] TICK_S = fbsmc_pkg::TICK_W'(TICK_SHORT_CYC - 1);
  localparam logic [fbsmc_pkg::TICK_W-1:0] TICK_L = fbsmc_pkg::TICK_W'(TICK_LONG_CYC - 1);

  fbsmc_pkg::fbsmc_state_t st_ff;
  fbsmc_pkg::fbsmc_state_t nxt_st;

  logic req;
  logic wrAcc;
  logic [31:0] wrMask;
  logic [31:0] rdValue;
  logic [1:0] lastWait;
  logic [fbsmc_pkg::TICK_W-1:0] tickLast;
  logic tickEv;
  logic refusedEv;
  logic [fbsmc_pkg::IRQ_W-1:0] irqClr;
  logic [fbsmc_pkg::IRQ_W-1:0] irqSet;

  // byte enables widened to a bit mask
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // merge write data into an old word under a bit mask
  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [31:0] m);
    mergeWord = (old & ~m) | (wd & m);
  endfunction

  assign req = avs_read | avs_write;
  // a write takes effect only at the edge where the master sees waitrequest low
  assign wrAcc = avs_write & ~st_ff.waitReq;
  assign wrMask = laneMask(avs_byteenable);
  assign lastWait = (st_ff.cfg.readyAdvance ? fbsmc_pkg::LAT_EARLY
                                            : fbsmc_pkg::LAT_NORMAL) - 2'h1;
  assign tickLast = st_ff.cfg.userTimebase ? TICK_L : TICK_S;

  // read mux: unmapped words read as zero
  always_comb begin
    unique case (avs_address[4:2])
      fbsmc_pkg::OFS_CFG[4:2]: rdValue = {16'h0000, 16'(st_ff.cfg) & fbsmc_pkg::CFG_WR_MASK};
      fbsmc_pkg::OFS_CTRL[4:2]: rdValue = {30'h0, st_ff.relCnt != '0, st_ff.online};
      fbsmc_pkg::OFS_STAT[4:2]: rdValue = {30'h0, st_ff.irqStat};
      fbsmc_pkg::OFS_MASK[4:2]: rdValue = {30'h0, st_ff.irqMask};
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tickPulse = 1'b0;
    tickEv = 1'b0;
    refusedEv = 1'b0;
    irqClr = '0;

    // bus handshake: waitrequest drops after lastWait+1 sampled request edges
    if (req && st_ff.waitReq) begin
      if (st_ff.cnt == lastWait) begin
        nxt_st.waitReq = 1'b0;
        nxt_st.rdata = rdValue;
      end else begin
        nxt_st.cnt = st_ff.cnt + 2'h1;
      end
    end else begin
      nxt_st.waitReq = 1'b1;
      nxt_st.cnt = 2'h0;
    end

    // release hold counts down
    if (st_ff.relCnt != '0) begin
      nxt_st.relCnt = st_ff.relCnt - fbsmc_pkg::REL_W'(1);
    end

    // register writes
    if (wrAcc) begin
      unique case (avs_address[4:2])
        fbsmc_pkg::OFS_CFG[4:2]: begin
          if (!st_ff.online) begin
            nxt_st.cfg = fbsmc_pkg::fbsmc_cfg_t'(16'(mergeWord({16'h0000, 16'(st_ff.cfg)},
              avs_writedata, wrMask)) & fbsmc_pkg::CFG_WR_MASK);
          end else begin
            refusedEv = 1'b1;
          end
        end
        fbsmc_pkg::OFS_CTRL[4:2]: begin
          if (avs_byteenable[0]) begin
            if (avs_writedata[fbsmc_pkg::CTRL_EOI]) begin
              nxt_st.relCnt = st_ff.cfg.irqReleaseTimebase ? REL_L : REL_S;
            end
            // going offline wins over a start in the same write
            if (avs_writedata[fbsmc_pkg::CTRL_OFFLINE]) begin
              nxt_st.online = 1'b0;
            end else if (avs_writedata[fbsmc_pkg::CTRL_START]) begin
              nxt_st.online = 1'b1;
            end
          end
        end
        fbsmc_pkg::OFS_STAT[4:2]: begin
          irqClr = avs_writedata[fbsmc_pkg::IRQ_W-1:0] & wrMask[fbsmc_pkg::IRQ_W-1:0];
        end
        fbsmc_pkg::OFS_MASK[4:2]: begin
          nxt_st.irqMask = fbsmc_pkg::IRQ_W'(mergeWord({30'h0, st_ff.irqMask},
                                                       avs_writedata, wrMask));
        end
        default: begin
        end
      endcase
    end

    // user tick, only while online
    if (!st_ff.online) begin
      nxt_st.tickCnt = '0;
    end else if (st_ff.tickCnt >= tickLast) begin
      nxt_st.tickCnt = '0;
      tickEv = 1'b1;
      nxt_st.tickPulse = 1'b1;
    end else begin
      nxt_st.tickCnt = st_ff.tickCnt + fbsmc_pkg::TICK_W'(1);
    end

    // sticky status: a new event wins over the clear
    irqSet = '0;
    irqSet[fbsmc_pkg::IRQ_TICK] = tickEv;
    irqSet[fbsmc_pkg::IRQ_REFUSED] = refusedEv;
    nxt_st.irqStat = (st_ff.irqStat & ~irqClr) | irqSet;

    // interrupt forced inactive while the release hold runs
    nxt_st.irq = (|(nxt_st.irqStat & nxt_st.irqMask)) && (nxt_st.relCnt == '0);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= fbsmc_pkg::STATE_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitReq;
  assign modeCfg = st_ff.cfg;
  assign protocolServicePoints = st_ff.cfg.slaveProtocolEnable;
  assign online = st_ff.online;
  assign userTick = st_ff.tickPulse;
  assign irq = st_ff.irq;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic reqStart;
  logic cfgWr;
  logic eoiWr;
  assign reqStart = req && st_ff.waitReq && (st_ff.cnt == 2'h0);
  assign cfgWr = wrAcc && (avs_address[4:2] == fbsmc_pkg::OFS_CFG[4:2]);
  assign eoiWr = wrAcc && (avs_address[4:2] == fbsmc_pkg::OFS_CTRL[4:2])
                 && avs_byteenable[0] && avs_writedata[fbsmc_pkg::CTRL_EOI];
  logic tickClr;
  // write-one-to-clear of the tick status bit
  assign tickClr = wrAcc && (avs_address[4:2] == fbsmc_pkg::OFS_STAT[4:2])
                   && avs_byteenable[0] && avs_writedata[fbsmc_pkg::IRQ_TICK];

  ready_normal_a:
  assert property ((reqStart && !st_ff.cfg.readyAdvance && ce) ##1 ce
                   |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("default ready not after two waits");

  ready_early_a:
  assert property ((reqStart && st_ff.cfg.readyAdvance && ce) |=> !avs_waitrequest)
    else $error("advanced ready not one cycle earlier");

  read_data_a:
  assert property ((avs_read && !avs_waitrequest && avs_address[4:2] == 3'h0)
                   |-> avs_readdata == {16'h0000, 16'(modeCfg)})
    else $error("read data not valid with ready");

  sync_apply_a:
  assert property ((cfgWr && !online && avs_byteenable[0] && ce)
                   |=> modeCfg.syncSupported == $past(avs_writedata[6]))
    else $error("sync capability not applied");

  freeze_apply_a:
  assert property ((cfgWr && !online && avs_byteenable[0] && ce)
                   |=> modeCfg.freezeSupported == $past(avs_writedata[7]))
    else $error("freeze capability not applied");

  proto_apply_a:
  assert property ((cfgWr && !online && avs_byteenable[1] && ce)
                   |=> protocolServicePoints == $past(avs_writedata[8]))
    else $error("protocol enable not applied");

  release_load_a:
  assert property ((eoiWr && ce) |=> st_ff.relCnt ==
                   ($past(modeCfg.irqReleaseTimebase) ? REL_L : REL_S) && !irq)
    else $error("release hold not loaded");

  release_hold_a:
  assert property ((st_ff.relCnt != '0) |-> !irq)
    else $error("interrupt active during release hold");

  tick_period_a:
  assert property ((online && st_ff.tickCnt == tickLast && ce)
                   |=> userTick && st_ff.irqStat[fbsmc_pkg::IRQ_TICK])
    else $error("user tick missed");

  refuse_online_a:
  assert property ((cfgWr && online && ce)
                   |=> $stable(modeCfg) && st_ff.irqStat[fbsmc_pkg::IRQ_REFUSED])
    else $error("online configuration write not refused");

  cfg_stable_a:
  assert property (!(cfgWr && !online) |=> $stable(modeCfg))
    else $error("configuration changed without a write");

  param_buf_apply_a:
  assert property ((cfgWr && !online && avs_byteenable[1] && ce)
                   |=> modeCfg.directParamBuf == $past(avs_writedata[12]))
    else $error("parameter buffer mode not applied");

  fail_safe_apply_a:
  assert property ((cfgWr && !online && avs_byteenable[1] && ce)
                   |=> modeCfg.failSafeClear == $past(avs_writedata[13]))
    else $error("fail-safe clear mode not applied");

  watchdog_apply_a:
  assert property ((cfgWr && !online && avs_byteenable[1] && ce)
                   |=> modeCfg.watchdogTestSelect == $past(avs_writedata[11]))
    else $error("watchdog test field not applied");

  ready_once_a:
  assert property ((!avs_waitrequest && ce) |=> avs_waitrequest)
    else $error("ready held for more than one cycle");

  mask_read_a:
  assert property ((avs_read && !avs_waitrequest
                    && avs_address[4:2] == fbsmc_pkg::OFS_MASK[4:2])
                   |-> avs_readdata == {30'h0, st_ff.irqMask})
    else $error("mask read data not valid with ready");

  release_count_a:
  assert property ((st_ff.relCnt != '0 && !eoiWr && ce)
                   |=> st_ff.relCnt == $past(st_ff.relCnt) - fbsmc_pkg::REL_W'(1))
    else $error("release hold not counting down");

  irq_masked_a:
  assert property ((st_ff.irqStat & st_ff.irqMask) == '0 |-> !irq)
    else $error("interrupt active with nothing unmasked");

  tick_sticky_a:
  assert property ((st_ff.irqStat[fbsmc_pkg::IRQ_TICK] && !tickClr && ce)
                   |=> st_ff.irqStat[fbsmc_pkg::IRQ_TICK])
    else $error("tick status lost without a clear");

  offline_quiet_a:
  assert property ((!online && ce) |=> !userTick)
    else $error("user tick while offline");

  early_read_c: cover property (reqStart && avs_read && st_ff.cfg.readyAdvance);
  long_release_c: cover property (eoiWr && modeCfg.irqReleaseTimebase);
  tick_irq_c: cover property (userTick && irq);
  refused_c: cover property (cfgWr && online);
  frozen_tick_c: cover property (!ce && online && st_ff.tickCnt != '0);

endmodule // fbsmc_mode_config

// >>> fbsmc_host_model.sv
// fbsmc_host_model: host processor model, an avalon-mm master of the config block
// assumes sys_clk is shared with the block and waitrequest comes from a register
`timescale 1ns/10ps
module fbsmc_host_model (
  // clock
  input wire logic sys_clk,
  // avalon-mm master
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // one transfer; n counts edges from raising the request to the answer
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q, output int n);
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not keep looking valid
    avs_writedata <= ~d;
  endtask
  // config words never carry the watchdog test bit; called only while offline
  task automatic cfg_write(input logic [15:0] v, output int n);
    logic [31:0] q;
    xfer(1'b1, fbsmc_pkg::OFS_CFG, {16'h0, v & 16'hF7FF}, q, n);
  endtask
endmodule // fbsmc_host_model

// >>> test_fbsmc_mode_config.sv
// test_fbsmc_mode_config: self-checking bench of the mode configuration block
// assumes the host model drives the bus and shortened tick counts and a shortened long release count
`timescale 1ns/10ps
module test_fbsmc_mode_config;
  localparam int REL_L = 40;
  localparam int TICK_S = 10;
  localparam int TICK_L = 30;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, protocolServicePoints, online, userTick, irq;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  fbsmc_pkg::fbsmc_cfg_t modeCfg;
  int n_mismatch = 0;
  int check_count = 0;
  int tickGap = 0;
  int tickRun = 0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tickGap <= (userTick === 1'b1) ? tickRun : tickGap;
    tickRun <= (userTick === 1'b1) ? 1 : tickRun + 1;
  end
  fbsmc_mode_config #(.REL_LONG_CYC(REL_L), .TICK_SHORT_CYC(TICK_S), .TICK_LONG_CYC(TICK_L))
    fbsmc_mode_config_inst (.sys_clk(sys_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .modeCfg(modeCfg),
    .protocolServicePoints(protocolServicePoints), .online(online), .userTick(userTick),
    .irq(irq));
  fbsmc_host_model fbsmc_host_model_inst (.sys_clk(sys_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q, output int n);
    fbsmc_host_model_inst.xfer(1'b0, a, 32'h0, q, n);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    int n;
    fbsmc_host_model_inst.xfer(1'b1, a, d, q, n);
    chk_rng("write answer", 1, 49, n);
  endtask
  task automatic cfg(input logic [15:0] v);
    int n;
    fbsmc_host_model_inst.cfg_write(v, n);
    // the new value shows only after the accepting edge has been registered
    @(negedge sys_clk);
    chk("cfg field", {16'h0, v}, {16'h0, modeCfg});
  endtask
  task automatic test_reset();
    logic [31:0] q;
    int n;
    rd(fbsmc_pkg::OFS_CFG, q, n);
    chk("cfg reset", {16'h0, fbsmc_pkg::CFG_RST}, q);
    chk("normal wait", 32'h3, 32'(n));
    rd(5'h1C, q, n);
    chk("unmapped", 32'h0, q);
    rd(fbsmc_pkg::OFS_MASK, q, n);
    chk("mask reset", {30'h0, fbsmc_pkg::MASK_RST}, q);
  endtask
  task automatic test_early();
    logic [31:0] q;
    int n;
    cfg(16'h0020);
    rd(fbsmc_pkg::OFS_CFG, q, n);
    chk("early wait", 32'h2, 32'(n));
    chk("early data", 32'h20, q);
    cfg(16'h0000);
    rd(fbsmc_pkg::OFS_CFG, q, n);
    chk("back to normal", 32'h3, 32'(n));
  endtask
  task automatic test_fields();
    logic [31:0] q;
    int n;
    for (int b = 6; b < 14; b++) begin
      if (b != 11) begin
        cfg(16'(1 << b));
        chk("service points", 32'(b == 8), {31'h0, protocolServicePoints});
        chk("watchdog normal", 32'h0, {31'h0, modeCfg.watchdogTestSelect});
        rd(fbsmc_pkg::OFS_CFG, q, n);
        chk("cfg readback", 32'(1 << b), q);
      end
    end
  endtask
  task automatic test_tick(input logic base, input int per);
    cfg({5'h0, base, 10'h0});
    wr(fbsmc_pkg::OFS_MASK, 32'h1);
    wr(fbsmc_pkg::OFS_CTRL, 32'h1);
    @(negedge sys_clk);
    chk("online", 32'h1, {31'h0, online});
    repeat (3) begin
      for (int k = 0; k < 300 && userTick !== 1'b1; k++) @(posedge sys_clk);
      @(posedge sys_clk);
    end
    chk("tick period", 32'(per), 32'(tickGap));
    chk("tick irq", 32'h1, {31'h0, irq});
    wr(fbsmc_pkg::OFS_CTRL, 32'h4);
    wr(fbsmc_pkg::OFS_STAT, 32'h3);
  endtask
  task automatic test_freeze();
    cfg(16'h0000);
    wr(fbsmc_pkg::OFS_CTRL, 32'h1);
    for (int k = 0; k < 300 && userTick !== 1'b1; k++) @(posedge sys_clk);
    @(posedge sys_clk);
    // five frozen edges stretch the running tick period by five cycles
    ce <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ce <= 1'b1;
    for (int k = 0; k < 300 && userTick !== 1'b1; k++) @(posedge sys_clk);
    @(posedge sys_clk);
    chk("frozen tick", 32'(TICK_S + 5), 32'(tickGap));
    wr(fbsmc_pkg::OFS_CTRL, 32'h4);
    wr(fbsmc_pkg::OFS_STAT, 32'h3);
  endtask
  task automatic test_release(input logic base, input int hold);
    logic [31:0] q;
    int n;
    int k;
    cfg({6'h0, base, 9'h0});
    wr(fbsmc_pkg::OFS_MASK, 32'h1);
    wr(fbsmc_pkg::OFS_CTRL, 32'h1);
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(negedge sys_clk);
    wr(fbsmc_pkg::OFS_CTRL, 32'h2);
    @(negedge sys_clk);
    chk("irq after eoi", 32'h0, {31'h0, irq});
    for (k = 0; k < 200 && irq !== 1'b1; k++) @(negedge sys_clk);
    chk_rng("release hold", hold, hold + 2, k);
    wr(fbsmc_pkg::OFS_MASK, 32'h0);
    @(negedge sys_clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(fbsmc_pkg::OFS_CTRL, 32'h4);
    wr(fbsmc_pkg::OFS_STAT, 32'h3);
    rd(fbsmc_pkg::OFS_STAT, q, n);
    chk("status cleared", 32'h0, q);
  endtask
  task automatic test_refused();
    logic [31:0] q;
    int n;
    cfg(16'h0100);
    wr(fbsmc_pkg::OFS_CTRL, 32'h1);
    // a config write while online must be ignored and flagged
    fbsmc_host_model_inst.xfer(1'b1, fbsmc_pkg::OFS_CFG, 32'h2000, q, n);
    @(negedge sys_clk);
    chk("cfg kept online", 32'h0100, {16'h0, modeCfg});
    rd(fbsmc_pkg::OFS_STAT, q, n);
    chk("refused flag", 32'h1, {31'h0, q[fbsmc_pkg::IRQ_REFUSED]});
    wr(fbsmc_pkg::OFS_CTRL, 32'h4);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_early();
    test_fields();
    test_tick(1'b0, TICK_S);
    test_tick(1'b1, TICK_L);
    test_freeze();
    test_release(1'b0, 25);
    test_release(1'b1, REL_L);
    test_refused();
    results();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule // test_fbsmc_mode_config
